/* File: hw/pdc_pkg.sv */
// Shared types, pin layout, command decoding and timing counts for the
// power-down controller. Assumes a 10 MHz core clock and a CK made by /2.
package pdc_pkg;

   // ************************************************************
   // Clocks and timing
   // ************************************************************
   localparam int CORE_PERIOD_NS = 100;
   localparam int CK_DIV = 2;
   localparam int CK_PERIOD_NS = CORE_PERIOD_NS * CK_DIV;

   // Least times round up, in CK cycles
   function automatic int cyc_min(input int ns, input int nck);
      int c;
      c = (ns + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
      if (c < nck) c = nck;
      if (c < 1) c = 1;
      return c;
   endfunction

   localparam int T_CKE_NS = 5;
   localparam int T_CKE_NCK = 3;
   localparam int T_XP_NS = 6;
   localparam int T_XP_NCK = 3;
   localparam int T_EXIT_DLL_NS = 24;
   localparam int T_EXIT_DLL_NCK = 10;
   localparam int T_ENTRY_CMD_NCK = 1;
   localparam int T_RFC_NS = 160;
   localparam int T_REFI_NS = 7800;
   localparam int PD_REFI_MULT = 9;

   localparam int CKE_CYC = cyc_min(T_CKE_NS, T_CKE_NCK);
   localparam int XP_CYC = cyc_min(T_XP_NS, T_XP_NCK);
   localparam int EXIT_DLL_CYC = cyc_min(T_EXIT_DLL_NS, T_EXIT_DLL_NCK);
   localparam int ENTRY_CMD_CYC = cyc_min(0, T_ENTRY_CMD_NCK);
   localparam int RFC_CYC = cyc_min(T_RFC_NS, 1);
   // Longest time rounds down
   localparam int PD_MAX_CYC = PD_REFI_MULT * (T_REFI_NS / CK_PERIOD_NS);

   // ************************************************************
   // Timer bank
   // ************************************************************
   localparam int TM_W = 9;
   localparam int TM_CKE = 0;
   localparam int TM_XP = 1;
   localparam int TM_EXIT_DLL = 2;
   localparam int TM_RFC = 3;
   localparam int TM_PD_MAX = 4;
   localparam int TM_ENTRY_CMD = 5;
   localparam int TM_N = 6;

   typedef struct packed {
      logic [TM_W-1:0] cnt;
   } pdc_tmr_t;

   typedef struct packed {
      logic ck;
      logic ck_n;
   } pdc_ckgen_t;

   // ************************************************************
   // Pins and commands
   // ************************************************************
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [2:0] ba;
      logic [12:0] addr;
   } pdc_cmd_t;

   typedef struct packed {
      logic reset_n;
      logic cke;
      logic termination_ctl_pin;
      pdc_cmd_t cmd;
   } pdc_pins_t;

   localparam pdc_cmd_t NO_OPERATION_CMD = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1,
                                             we_n: 1'b1, ba: 3'h0, addr: 13'h0000};

   typedef enum logic [1:0] {ST_RUN, ST_PD, ST_RST} pdc_state_t;

   typedef struct packed {
      pdc_state_t st;
      pdc_pins_t pins;
      logic slow;
      logic dll_bad_pd;
      logic dll_bad;
      logic entered_since_ref;
      logic ack;
      logic precharge_pd;
   } pdc_ctl_t;

   function automatic logic is_no_operation_cmd(input pdc_cmd_t c);
      return c.cs_n || (c.ras_n && c.cas_n && c.we_n);
   endfunction

   function automatic logic is_refresh_cmd(input pdc_cmd_t c);
      return !c.cs_n && !c.ras_n && !c.cas_n && c.we_n;
   endfunction

   function automatic logic is_read_cmd(input pdc_cmd_t c);
      return !c.cs_n && c.ras_n && !c.cas_n && c.we_n;
   endfunction

   function automatic logic is_mode_reg_set_cmd(input pdc_cmd_t c);
      return !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n;
   endfunction

endpackage

/* File: hw/pdc_timer.sv */
// Down-counter for one timing limit, counted in CK cycles.
// Assumes en_i pulses once per CK cycle and shares the core clock.
`timescale 1ns/1ps
module pdc_timer
   import pdc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic load_i,
   input wire logic [TM_W-1:0] value_i,
   output logic done_o
);

   pdc_tmr_t r;
   pdc_tmr_t nxt;

   always_comb begin
      nxt = r;
      if (en_i) begin
         if (load_i) begin
            nxt.cnt = value_i;
         end else if (r.cnt != '0) begin
            nxt.cnt = r.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign done_o = (r.cnt == '0);

endmodule // pdc_timer

/* File: hw/pdc_ck_gen.sv */
// Divide-by-two generator of the differential memory clock.
// Apart from a memory reset on dram_rst_i, which acts on any core edge with ce_i high, pins update on the core edge that drops CK, so they are stable at its rise.
`timescale 1ns/1ps
module pdc_ck_gen
   import pdc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   output logic ck_o,
   output logic ck_n_o,
   output logic tick_o
);

   pdc_ckgen_t r;
   pdc_ckgen_t nxt;

   always_comb begin
      nxt.ck = !r.ck;
      nxt.ck_n = r.ck;
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{ck: 1'b0, ck_n: 1'b1};
      end else if (ce_i) begin
         r <= nxt;
      end
   end

   assign ck_o = r.ck;
   assign ck_n_o = r.ck_n;
   // Next edge drops CK
   assign tick_o = r.ck && ce_i;

endmodule // pdc_ck_gen

/* File: hw/pdc_ctrl.sv */
// Host-side power-down controller: forwards user commands to the memory
// pins and enters and leaves power-down under all timing limits.
// Assumes user inputs are on core_clk_i; the memory clock is made here.
`timescale 1ns/1ps

// Notes on behaviour
// - Enter with clock-enable low plus idle command
// - No entry during busy operations
// - Entry allowed while refresh or precharge runs
// - Unlocked DLL at entry needs reset later
// - Idle commands at entry and entry delay
// - Hold clock-enable low, reset high, termination
// - Clock-enable held each level minimum time
// - Power-down shorter than nine refresh intervals
// - Exit with idle command, then wait latency
// - Minimum power-down time before exit
// - DLL exit latency before next entry
// - Idle commands until refresh cycle elapses
// - No second entry within refresh cycle
// - Refresh encoding: select, row, column low
module pdc_ctrl
   import pdc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic pd_req_i,
   input wire logic op_busy_i,
   input wire logic bank_open_i,
   input wire logic pd_dll_keep_bit_i,
   input wire logic dll_locked_i,
   input wire logic dram_rst_i,
   input wire logic termination_ctl_i,
   input wire logic cmd_valid_i,
   input wire pdc_cmd_t cmd_i,
   output logic cmd_ack_o,
   output pdc_pins_t pins_o,
   output logic ck_o,
   output logic ck_n_o,
   output logic pd_active_o,
   output logic precharge_pd_o,
   output logic dll_reset_needed_o
);

   // ************************************************************
   // Clock and timers
   // ************************************************************
   logic tick;
   logic [TM_N-1:0] tm_load;
   logic [TM_N-1:0] tm_done;
   logic [TM_W-1:0] tm_val [TM_N];

   pdc_ck_gen u_ck (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .ck_o(ck_o),
      .ck_n_o(ck_n_o),
      .tick_o(tick)
   );

   assign tm_val[TM_CKE] = TM_W'(CKE_CYC);
   assign tm_val[TM_XP] = TM_W'(XP_CYC);
   assign tm_val[TM_EXIT_DLL] = TM_W'(EXIT_DLL_CYC);
   assign tm_val[TM_RFC] = TM_W'(RFC_CYC);
   assign tm_val[TM_PD_MAX] = TM_W'(PD_MAX_CYC);
   assign tm_val[TM_ENTRY_CMD] = TM_W'(ENTRY_CMD_CYC);

   // Every limit is a loaded down-counter
   generate
      for (genvar i = 0; i < TM_N; i++) begin : g_tm
         pdc_timer u_tm (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .en_i(tick),
            .load_i(tm_load[i]),
            .value_i(tm_val[i]),
            .done_o(tm_done[i])
         );
      end
   endgenerate

   // ************************************************************
   // Control
   // ************************************************************
   pdc_ctl_t r;
   pdc_ctl_t nxt;
   logic cmd_ok;
   logic entry_ok;
   logic exit_ok;
   logic dll_paths_ok;

   always_comb begin
      // All commands and termination wait for the DLL only after a slow exit
      dll_paths_ok = !r.slow || tm_done[TM_EXIT_DLL];
      cmd_ok = cmd_valid_i && tm_done[TM_XP] && dll_paths_ok
               && (tm_done[TM_RFC] || is_no_operation_cmd(cmd_i))
               && !(is_read_cmd(cmd_i) && r.dll_bad);
      entry_ok = pd_req_i && !cmd_valid_i && !op_busy_i
                 && tm_done[TM_CKE] && tm_done[TM_XP]
                 && tm_done[TM_EXIT_DLL]
                 && !(!tm_done[TM_RFC] && r.entered_since_ref);
      exit_ok = (!pd_req_i || tm_done[TM_PD_MAX])
                && tm_done[TM_CKE] && tm_done[TM_ENTRY_CMD];
   end

   always_comb begin
      nxt = r;
      nxt.ack = 1'b0;
      tm_load = '0;
      if (tick) begin
         case (r.st)
            ST_RST: begin
               nxt.pins.reset_n = 1'b1;
               nxt.pins.cke = 1'b1;
               nxt.pins.cmd = NO_OPERATION_CMD;
               nxt.st = ST_RUN;
               nxt.slow = 1'b0;
               nxt.dll_bad = 1'b0;
               nxt.entered_since_ref = 1'b0;
               tm_load[TM_CKE] = 1'b1;
               // Commands after reset release also wait the exit latency
               tm_load[TM_XP] = 1'b1;
            end
            ST_RUN: begin
               nxt.pins.cmd = NO_OPERATION_CMD;
               if (dll_paths_ok) begin
                  nxt.pins.termination_ctl_pin = termination_ctl_i;
               end
               if (entry_ok) begin
                  // Clock-enable falls with an idle command
                  nxt.pins.cke = 1'b0;
                  nxt.st = ST_PD;
                  nxt.precharge_pd = !bank_open_i;
                  nxt.slow = !bank_open_i && !pd_dll_keep_bit_i;
                  nxt.dll_bad_pd = !dll_locked_i;
                  nxt.entered_since_ref = !tm_done[TM_RFC];
                  tm_load[TM_CKE] = 1'b1;
                  tm_load[TM_PD_MAX] = 1'b1;
                  tm_load[TM_ENTRY_CMD] = 1'b1;
               end else if (cmd_ok) begin
                  nxt.pins.cmd = cmd_i;
                  nxt.ack = 1'b1;
                  if (is_refresh_cmd(cmd_i)) begin
                     tm_load[TM_RFC] = 1'b1;
                     nxt.entered_since_ref = 1'b0;
                  end
                  if (is_mode_reg_set_cmd(cmd_i)) begin
                     nxt.dll_bad = 1'b0;
                  end
               end
            end
            ST_PD: begin
               // Pins frozen apart from clock-enable
               nxt.pins.cmd = NO_OPERATION_CMD;
               if (exit_ok) begin
                  nxt.pins.cke = 1'b1;
                  nxt.st = ST_RUN;
                  nxt.dll_bad = r.dll_bad_pd;
                  tm_load[TM_CKE] = 1'b1;
                  tm_load[TM_XP] = 1'b1;
                  tm_load[TM_EXIT_DLL] = 1'b1;
               end
            end
            default: begin
               nxt.st = ST_RST;
            end
         endcase
      end
      // Reset pin drops at once, leaving power-down
      if (dram_rst_i) begin
         nxt.st = ST_RST;
         nxt.pins.reset_n = 1'b0;
         nxt.pins.cke = 1'b0;
         nxt.pins.termination_ctl_pin = 1'b0;
         nxt.pins.cmd = NO_OPERATION_CMD;
         nxt.ack = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{st: ST_RST,
                pins: '{reset_n: 1'b0, cke: 1'b0, termination_ctl_pin: 1'b0,
                        cmd: NO_OPERATION_CMD},
                default: 1'b0};
      end else if (ce_i) begin
         r <= nxt;
      end
   end

   assign pins_o = r.pins;
   assign cmd_ack_o = r.ack;
   assign pd_active_o = (r.st == ST_PD);
   assign precharge_pd_o = r.precharge_pd;
   assign dll_reset_needed_o = r.dll_bad;

   // ************************************************************
   // Checks
   // ************************************************************
   // Ages count core cycles, two per CK
   localparam int PD_LIMIT = 2 * PD_MAX_CYC + 2;
   localparam int DLL_AGE = 2 * EXIT_DLL_CYC - 1;
   localparam int RFC_AGE = 2 * RFC_CYC;
   logic [9:0] pd_age;
   logic [7:0] exit_age;
   logic [7:0] ref_age;
   logic [1:0] falls_since_ref;
   // Delayed copies keep sampled-value calls out of the counters
   logic cke_q;
   logic was_pd;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pd_age <= 10'h000;
         exit_age <= 8'hff;
         ref_age <= 8'hff;
         falls_since_ref <= 2'h0;
         cke_q <= 1'b0;
         was_pd <= 1'b0;
      end else begin
         cke_q <= r.pins.cke;
         was_pd <= (r.st == ST_PD);
         pd_age <= (r.st == ST_PD) ? pd_age + 10'h001 : 10'h000;
         // Only a rise out of power-down restarts the exit age
         exit_age <= (r.st == ST_RUN && r.pins.cke && !cke_q && was_pd) ? 8'h00 :
                     (exit_age == 8'hff ? exit_age : exit_age + 8'h01);
         if (is_refresh_cmd(r.pins.cmd) && r.ack) begin
            ref_age <= 8'h00;
            falls_since_ref <= 2'h0;
         end else begin
            ref_age <= (ref_age == 8'hff) ? ref_age : ref_age + 8'h01;
            if (cke_q && !r.pins.cke && falls_since_ref != 2'h3) begin
               falls_since_ref <= falls_since_ref + 2'h1;
            end
         end
      end
   end

   sequence s_idle_6;
      is_no_operation_cmd(r.pins.cmd) [*6];
   endsequence

   sequence s_cke_low_6;
      !r.pins.cke [*6];
   endsequence

   chk_entry_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($fell(r.pins.cke) && r.pins.reset_n) |-> is_no_operation_cmd(r.pins.cmd) && pd_active_o)
      else $error("entry without idle command");

   chk_entry_not_busy: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($fell(r.pins.cke) && r.st == ST_PD) |-> !$past(op_busy_i))
      else $error("entry while an operation was busy");

   chk_low_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($fell(r.pins.cke) && r.st == ST_PD && !dram_rst_i) |-> s_cke_low_6 or (##[0:5] dram_rst_i))
      else $error("clock-enable low too short");

   chk_exit_latency: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($rose(r.pins.cke) && r.st == ST_RUN && !dram_rst_i) |-> s_idle_6 or (##[0:5] dram_rst_i))
      else $error("command before exit latency");

   chk_pd_pins: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (r.st == ST_PD) |-> r.pins.reset_n && !r.pins.cke && is_no_operation_cmd(r.pins.cmd)
                          && $stable(r.pins.termination_ctl_pin))
      else $error("pins moved during power-down");

   chk_pd_bound: assert property (@(posedge core_clk_i) disable iff (rst_i)
      pd_age <= 10'(PD_LIMIT))
      else $error("power-down too long");

   chk_slow_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (r.ack && is_read_cmd(r.pins.cmd) && r.slow) |-> exit_age >= 8'(DLL_AGE))
      else $error("read before DLL exit latency");

   chk_ref_window: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($fell(r.pins.cke) && ref_age < 8'(RFC_AGE)) |-> falls_since_ref == 2'h0)
      else $error("second entry inside refresh window");

   chk_reset_abort: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (dram_rst_i && ce_i) |=> !r.pins.reset_n && !pd_active_o)
      else $error("reset did not abort power-down");

   chk_entry_after_exit: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($fell(r.pins.cke) && r.st == ST_PD) |-> exit_age >= 8'(DLL_AGE))
      else $error("entry too soon after exit");

   chk_read_dll_block: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (r.ack && is_read_cmd(r.pins.cmd)) |-> !$past(r.dll_bad))
      else $error("read while DLL reset pending");

   chk_entry_kind: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($fell(r.pins.cke) && r.st == ST_PD)
         |-> r.precharge_pd == !$past(bank_open_i)
             && r.slow == (!$past(bank_open_i) && !$past(pd_dll_keep_bit_i)))
      else $error("wrong power-down kind at entry");

endmodule // pdc_ctrl

/* File: bench/pdc_dram_model.sv */
// Behavioural memory device that samples the controller's pins.
// Assumes pins are stable at the rising edge of the memory clock.
`timescale 1ns/1ps
module pdc_dram_model
   import pdc_pkg::*;
(
   input wire logic ck_i,
   input wire pdc_pins_t pins_i,
   output logic pd_o,
   output logic pd_pre_o,
   output logic dll_off_o,
   output int viol_o
);
   // ************************************************************
   // Pin sampling
   // ************************************************************
   logic cke_q = 1'b0;
   logic keep = 1'b0;
   logic [7:0] banks = 8'h00;
   logic idle;
   int since = 0;
   int since_ref = 1000;
   pdc_cmd_t c;
   initial begin
      pd_o = 1'b0;
      pd_pre_o = 1'b0;
      dll_off_o = 1'b0;
      viol_o = 0;
   end
   always @(posedge ck_i) begin
      c = pins_i.cmd;
      idle = c.cs_n | (c.ras_n & c.cas_n & c.we_n);
      since = since + 1;
      since_ref = since_ref + 1;
      if (pins_i.reset_n !== 1'b1) begin
         pd_o = 1'b0;
         banks = 8'h00;
         since = 0;
      end else if (cke_q && !pins_i.cke) begin
         if (!idle) viol_o++;
         pd_o = 1'b1;
         pd_pre_o = (banks == 8'h00);
         dll_off_o = (banks == 8'h00) && !keep;
         since = 0;
      end else if (pd_o) begin
         // Receivers off: only enable and reset count
         if (pins_i.cke) begin
            if (!idle || since < CKE_CYC || since > PD_MAX_CYC + 2) viol_o++;
            pd_o = 1'b0;
            since = 0;
         end
      end else if (!idle) begin
         if (since < XP_CYC || (dll_off_o && c.ras_n && !c.cas_n && c.we_n &&
             since < EXIT_DLL_CYC)) viol_o++;
         if (!c.ras_n && c.cas_n && c.we_n) banks[c.ba] = 1'b1;
         if (!c.ras_n && c.cas_n && !c.we_n) banks = c.addr[10] ? 8'h00 : banks & ~(8'h01 << c.ba);
         if (since_ref < RFC_CYC) viol_o++;
         if (!c.ras_n && !c.cas_n && c.we_n) begin
            banks = 8'h00;
            since_ref = 0;
         end
         if (!c.ras_n && !c.cas_n && !c.we_n && c.ba == 3'h0) keep = c.addr[12];
      end
      cke_q = pins_i.cke;
   end
endmodule // pdc_dram_model

/* File: bench/dram_power_down_control_bench.sv */
// Self-checking bench for the power-down controller with a device model.
// Assumes the controller makes the memory clock from the core clock.
`timescale 1ns/1ps
module dram_power_down_control_bench;
   import pdc_pkg::*;
   // ************************************************************
   // Stimulus and observation
   // ************************************************************
   localparam logic [3:0] K_ACT = 4'h3;
   localparam logic [3:0] K_RD = 4'h5;
   localparam logic [3:0] K_PRE = 4'h2;
   localparam logic [3:0] K_MRS = 4'h0;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pd_req_i = 1'b0, op_busy_i = 1'b0, bank_open_i = 1'b0, keep_i = 1'b0;
   logic locked_i = 1'b1, dram_rst_i = 1'b0, term_i = 1'b0, cmd_valid_i = 1'b0;
   logic ce_i = 1'b1;
   logic [23:0] frz;
   pdc_cmd_t cmd_i = NO_OPERATION_CMD;
   pdc_pins_t pins_o;
   logic cmd_ack_o, ck_o, ck_n_o, pd_active_o, precharge_pd_o, dll_reset_needed_o;
   logic m_pd, m_pre, m_dll_off;
   int m_viol, n, ex;
   int err_total = 0;
   int compares = 0;
   int seed = 32'he9e3;
   pdc_cmd_t exp_q[$];
   logic [3:0] kinds[5] = '{4'h3, 4'h5, 4'h4, 4'h2, 4'h1};

   always #50 core_clk_i = ~core_clk_i;

   pdc_ctrl u_pdc_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .pd_req_i(pd_req_i), .op_busy_i(op_busy_i), .bank_open_i(bank_open_i),
      .pd_dll_keep_bit_i(keep_i), .dll_locked_i(locked_i), .dram_rst_i(dram_rst_i),
      .termination_ctl_i(term_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
      .cmd_ack_o(cmd_ack_o), .pins_o(pins_o), .ck_o(ck_o), .ck_n_o(ck_n_o),
      .pd_active_o(pd_active_o), .precharge_pd_o(precharge_pd_o),
      .dll_reset_needed_o(dll_reset_needed_o));
   pdc_dram_model u_pdc_dram_model (.ck_i(ck_o), .pins_i(pins_o), .pd_o(m_pd),
      .pd_pre_o(m_pre), .dll_off_o(m_dll_off), .viol_o(m_viol));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask
   function automatic pdc_cmd_t mk(input logic [3:0] k, input logic [2:0] b, input logic [12:0] a);
      return {k, b, a};
   endfunction
   // Holds the request until the ack; a refused one is withdrawn at the limit
   task automatic send(input pdc_cmd_t c, input int lim, output int w);
      cmd_i = c;
      cmd_valid_i = 1'b1;
      exp_q.push_back(c);
      w = 0;
      do begin
         tick(1);
         w++;
      end while (cmd_ack_o !== 1'b1 && w < lim);
      cmd_valid_i = 1'b0;
      if (cmd_ack_o === 1'b1) chk(32'(pins_o.cmd), 32'(exp_q.pop_front()));
      else void'(exp_q.pop_front());
   endtask
   task automatic wpd(input logic lvl, output int w);
      w = 0;
      while (pd_active_o !== lvl && w < 1000) begin
         tick(1);
         w++;
      end
   endtask
   task automatic pd_cycle(input logic bank, input logic keep, input logic locked);
      int w;
      send(mk(bank ? K_ACT : K_PRE, 3'h0, 13'h0400), 60, w);
      send(mk(K_MRS, 3'h0, {keep, 12'h000}), 60, w);
      bank_open_i = bank;
      keep_i = keep;
      locked_i = locked;
      term_i = 1'($random(seed));
      op_busy_i = 1'b1;
      pd_req_i = 1'b1;
      tick(12);
      chk(32'(pd_active_o), 0);
      chk(32'(pins_o.termination_ctl_pin), 32'(term_i));
      op_busy_i = 1'b0;
      wpd(1'b1, w);
      chk(32'(w <= 4), 1);
      chk(32'({pins_o.reset_n, pins_o.cke}), 2);
      pd_req_i = 1'b0;
      wpd(1'b0, w);
      chk(32'(w >= 2 * CKE_CYC && w <= 2 * CKE_CYC + 3), 1);
      chk(32'({precharge_pd_o, m_pre}), bank ? 0 : 3);
      chk(32'({dll_reset_needed_o, m_dll_off}), 32'({!locked, !bank && !keep}));
   endtask
   task automatic conclude();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      repeat (3) @(posedge core_clk_i);
      chk(32'({pins_o.reset_n, pins_o.cke}), 0);
      #1 rst_i = 1'b0;
      tick(8);
      chk(32'({pins_o.reset_n, pins_o.cke, ck_n_o ^ ck_o}), 7);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         send(mk(kinds[i], 3'($random(seed)), 13'($random(seed))), 60, n);
      end
      $display("test commands done");
      for (int i = 0; i < 4; i++) begin
         pd_cycle(i[0], i[1], 1'b1);
         send(mk(K_RD, 3'h0, 13'($random(seed))), 60, n);
         ex = (!i[0] && !i[1]) ? 2 * EXIT_DLL_CYC : 2 * XP_CYC;
         chk(32'(n >= ex && n <= ex + 3), 1);
      end
      $display("test power-down kinds done");
      pd_cycle(1'b0, 1'b1, 1'b0);
      send(mk(K_RD, 3'h0, 13'h0000), 60, n);
      chk(32'(n), 60);
      send(mk(K_MRS, 3'h0, 13'h1100), 60, n);
      tick(2);
      chk(32'(dll_reset_needed_o), 0);
      $display("test unlocked entry done");
      // Early entry straight after a refresh
      send(mk(4'h1, 3'h0, 13'h0000), 60, n);
      pd_req_i = 1'b1;
      wpd(1'b1, n);
      wpd(1'b0, n);
      chk(32'(n >= 2 * PD_MAX_CYC - 4 && n <= 2 * PD_MAX_CYC + 4), 1);
      wpd(1'b1, n);
      chk(32'(n >= 2 * EXIT_DLL_CYC), 1);
      dram_rst_i = 1'b1;
      tick(4);
      chk(32'({pins_o.reset_n, pins_o.cke, pd_active_o}), 0);
      tick(4);
      chk(32'(m_pd), 0);
      pd_req_i = 1'b0;
      dram_rst_i = 1'b0;
      tick(10);
      chk(32'({pins_o.reset_n, pins_o.cke}), 3);
      $display("test long hold and reset done");
      frz = {ck_o, pins_o};
      ce_i = 1'b0;
      term_i = ~term_i;
      tick(6);
      chk(32'({ck_o, pins_o}), 32'(frz));
      ce_i = 1'b1;
      tick(4);
      $display("test clock enable done");
      chk(32'(m_viol), 0);
      conclude();
   end
   initial begin
      #(100 * 20000);
      err_total++;
      conclude();
   end
endmodule // dram_power_down_control_bench
